//--- core/ast_uart_tx.v
// Transmit side of an asynchronous serial interface with a Wishbone register file.
// Assumes a classic Wishbone master on core_clk; rx_data_pin synchronous to core_clk.
// One bit lasts 16 periods of the transmit divisor, restarted at each frame.
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.vh"
module ast_uart_tx (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Serial pins
    output reg         tx_data_pin,
    output reg         tx_data_oe,
    input  wire        rx_data_pin,
    // Interrupt and cpu mask
    input  wire        cpu_int_mask,
    output reg         irq,
    output reg         irq_level
);
    // Transmit sequencer states
    localparam ST_IDLE  = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_DATA  = 3'd2;
    localparam ST_STOP  = 3'd3;
    localparam ST_MARK  = 3'd4;
    // Reset pattern of the two status flags, empty flag in bit 1
    localparam [1:0] ST_RST = `AST_RST_STATUS;

    // Software-visible control and baud registers
    reg [7:0]  ctrl1_q;
    reg [7:0]  ctrl2_q;
    reg [15:0] txbaud_q;
    reg [15:0] rxbaud_q;
    reg [1:0]  imask_q;

    // Status flags and the armed half of the clear sequence
    reg        tde_q;
    reg        tc_q;
    reg        st_seen_q;

    // Holding buffer between the bus and the shifter
    reg [7:0]  hold_q;
    reg        hold_b8_q;
    reg        hold_full_q;

    // Shifter and frame sequencer
    reg [8:0]  shift_q;
    reg [3:0]  bit_cnt_q;
    reg [2:0]  state_q;
    reg        idle_frm_q;
    reg        brk_frm_q;
    reg        te_dly_q;
    reg        brk_dly_q;

    // Baud dividers and oversample counters
    reg [15:0] tx_div_q;
    reg [3:0]  tx_ovs_q;
    reg [15:0] rx_div_q;
    reg [3:0]  rx_ovs_q;

    // Receive input filter
    reg [2:0]  rx_hist_q;
    reg        rx_filt_q;

    // Register decode, one aligned word each
    function is_addr;
        input [7:0] adr;
        input [7:0] want;
        begin
            is_addr = (adr == want);
        end
    endfunction

    // Bus qualifiers and field taps
    wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_data  = bus_req & wb_we_i & wb_sel_i[0] & is_addr(wb_adr_i, `AST_ADDR_DATA);
    wire acc_stat = bus_req & is_addr(wb_adr_i, `AST_ADDR_STATUS);
    wire te       = ctrl2_q[`AST_C2_TE];
    wire send_break_bit      = ctrl2_q[`AST_C2_SBK];
    wire nine     = ctrl1_q[`AST_C1_M];
    // R08 transmit baud tick
    wire tx_tick  = (tx_div_q == 16'h0000) & (tx_ovs_q == `AST_OVS);
    // R08 receive oversample tick, independent rate
    wire rx_samp  = (rx_div_q == 16'h0000);
    // Index of the final data bit for the selected word length
    wire [3:0] last_bit = nine ? 4'h8 : 4'h7;
    wire frame_end = tx_tick & (state_q == ST_STOP);
    wire te_rise  = te & ~te_dly_q;
    wire start_direct = wr_data & te & (state_q == ST_IDLE) & ~hold_full_q & ~te_rise;
    // A frame starts on enable, on a direct load, or from idle on break, mark or a queued byte
    wire frame_go = te & (te_rise | start_direct |
                    ((state_q == ST_IDLE) & (send_break_bit | brk_dly_q | hold_full_q)));
    // Queued byte leaves the holding buffer for the shifter
    wire hold_move = (state_q == ST_IDLE) & hold_full_q & te & ~send_break_bit & ~brk_dly_q;
    // Interrupt requests before the cpu mask
    wire empty_req = tde_q & ctrl2_q[`AST_C2_TIE];
    wire done_req  = tc_q & ctrl2_q[`AST_C2_TX_COMPLETE_INT_ENABLE];

    // Bus answer: one wait state, zero for unmapped addresses
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            // Ack masks bus_req, so a held request is taken only once
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h00000000;
            if (bus_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `AST_ADDR_STATUS: wb_dat_o <= {24'h000000, tde_q, tc_q, 6'h00};
                    `AST_ADDR_CTRL1:  wb_dat_o <= {24'h000000, ctrl1_q};
                    `AST_ADDR_CTRL2:  wb_dat_o <= {24'h000000, ctrl2_q};
                    `AST_ADDR_TXBAUD: wb_dat_o <= {16'h0000, txbaud_q};
                    `AST_ADDR_RXBAUD: wb_dat_o <= {16'h0000, rxbaud_q};
                    `AST_ADDR_IMASK:  wb_dat_o <= {24'h000000, imask_q, 6'h00};
                    default:          wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Writable control registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl1_q  <= `AST_RST_CTRL;
            ctrl2_q  <= `AST_RST_CTRL;
            txbaud_q <= `AST_RST_BAUD;
            rxbaud_q <= `AST_RST_BAUD;
            imask_q  <= 2'h0;
        end else if (bus_req & wb_we_i) begin
            if (is_addr(wb_adr_i, `AST_ADDR_CTRL1) & wb_sel_i[0])
                ctrl1_q <= wb_dat_i[7:0];
            if (is_addr(wb_adr_i, `AST_ADDR_CTRL2) & wb_sel_i[0])
                ctrl2_q <= wb_dat_i[7:0];
            // Baud halves follow their byte lanes
            if (is_addr(wb_adr_i, `AST_ADDR_TXBAUD)) begin
                if (wb_sel_i[0]) txbaud_q[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) txbaud_q[15:8] <= wb_dat_i[15:8];
            end
            if (is_addr(wb_adr_i, `AST_ADDR_RXBAUD)) begin
                if (wb_sel_i[0]) rxbaud_q[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) rxbaud_q[15:8] <= wb_dat_i[15:8];
            end
            if (is_addr(wb_adr_i, `AST_ADDR_IMASK) & wb_sel_i[0])
                imask_q <= wb_dat_i[7:6];
        end
    end

    // Baud generators; divider reload keeps a stable rate
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_div_q <= 16'h0000;
            tx_ovs_q <= 4'h0;
            rx_div_q <= 16'h0000;
            rx_ovs_q <= 4'h0;
        end else begin
            if (~te) begin
                tx_div_q <= 16'h0000;
                tx_ovs_q <= 4'h0;
            end else if (frame_go) begin
                // Restart so every start bit gets a full bit time
                tx_div_q <= txbaud_q - 16'h0001;
                tx_ovs_q <= 4'h0;
            end else if (tx_div_q == 16'h0000) begin
                tx_div_q <= txbaud_q - 16'h0001;
                tx_ovs_q <= tx_ovs_q + 4'h1;
            end else begin
                tx_div_q <= tx_div_q - 16'h0001;
            end
            if (rx_div_q == 16'h0000) begin
                rx_div_q <= rxbaud_q - 16'h0001;
                rx_ovs_q <= rx_ovs_q + 4'h1;
            end else begin
                rx_div_q <= rx_div_q - 16'h0001;
            end
        end
    end

    // Receive path ends at the filtered level; no receiver is built here
    // R09 majority of three oversamples rejects single-sample glitches
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_hist_q <= 3'h7;
            rx_filt_q <= 1'b1;
        end else if (rx_samp & ctrl2_q[`AST_C2_RE]) begin
            rx_hist_q <= {rx_hist_q[1:0], rx_data_pin};
            rx_filt_q <= (rx_hist_q[0] & rx_hist_q[1]) | (rx_hist_q[1] & rx_data_pin) |
                         (rx_hist_q[0] & rx_data_pin);
        end
    end

    // Transmit sequencer
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            shift_q     <= 9'h1FF;
            bit_cnt_q   <= 4'h0;
            hold_q      <= 8'h00;
            hold_b8_q   <= 1'b0;
            hold_full_q <= 1'b0;
            idle_frm_q  <= 1'b0;
            brk_frm_q   <= 1'b0;
            te_dly_q    <= 1'b0;
            brk_dly_q   <= 1'b0;
        end else begin
            te_dly_q <= te;
            if (~te) begin
                // Dropping TE loses the holding buffer and cuts the frame
                state_q     <= ST_IDLE;
                hold_full_q <= 1'b0;
                brk_dly_q   <= 1'b0;
            end else if (te_rise) begin
                // R10 idle frame before first data
                state_q    <= ST_START;
                idle_frm_q <= 1'b1;
                brk_frm_q  <= 1'b0;
                shift_q    <= 9'h1FF;
                bit_cnt_q  <= 4'h0;
            end else begin
                // R14 write during frame lands in holding buffer
                if (wr_data & ~start_direct) begin
                    hold_q      <= wb_dat_i[7:0];
                    hold_b8_q   <= ctrl1_q[`AST_C1_T8];
                    hold_full_q <= 1'b1;
                end
                // R15 write while idle starts at once
                if (start_direct) begin
                    state_q    <= ST_START;
                    // R03 ninth bit from control; R19 unused when 8-bit
                    shift_q    <= {ctrl1_q[`AST_C1_T8], wb_dat_i[7:0]};
                    idle_frm_q <= 1'b0;
                    brk_frm_q  <= 1'b0;
                    bit_cnt_q  <= 4'h0;
                end else if (state_q == ST_IDLE) begin
                    // Idle-state starts, highest priority first
                    if (send_break_bit) begin
                        // R18 break frames while bit set
                        state_q   <= ST_START;
                        brk_frm_q <= 1'b1;
                        idle_frm_q <= 1'b0;
                        shift_q   <= 9'h000;
                        bit_cnt_q <= 4'h0;
                    end else if (brk_dly_q) begin
                        // R07 extra high bit after last break
                        state_q   <= ST_MARK;
                        brk_dly_q <= 1'b0;
                    end else if (hold_full_q) begin
                        // R14 buffered byte moves into the shifter
                        state_q     <= ST_START;
                        shift_q     <= {hold_b8_q, hold_q};
                        idle_frm_q  <= 1'b0;
                        brk_frm_q   <= 1'b0;
                        bit_cnt_q   <= 4'h0;
                        hold_full_q <= 1'b0;
                    end
                end else if (tx_tick) begin
                    case (state_q)
                        ST_START: state_q <= ST_DATA;
                        ST_DATA: begin
                            // R01 LSB first; R02 length from word select
                            // Ones fill from the top, so unused bits stay high
                            shift_q <= {1'b1, shift_q[8:1]};
                            if (bit_cnt_q == last_bit)
                                state_q <= ST_STOP;
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        ST_STOP: begin
                            state_q   <= ST_IDLE;
                            // Remember a break so the extra high bit follows
                            brk_dly_q <= brk_frm_q;
                        end
                        ST_MARK: state_q <= ST_IDLE;
                        default: state_q <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // Status flags; hardware set beats software clear
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tde_q     <= ST_RST[1];
            tc_q      <= ST_RST[0];
            st_seen_q <= 1'b0;
        end else begin
            // Any status access arms the clear; any data write disarms it
            if (acc_stat)
                st_seen_q <= 1'b1;
            else if (wr_data)
                st_seen_q <= 1'b0;
            // A direct load both sets and clears the empty flag; set wins
            // R11 status access then data write clears
            if (start_direct | hold_move)
                // R12 set when buffer transfers out; R15 set on direct load
                tde_q <= 1'b1;
            else if (wr_data & st_seen_q)
                tde_q <= 1'b0;
            // R16 set at frame end including break frames
            if (frame_end)
                tc_q <= 1'b1;
            // R17 same clearing sequence
            else if (wr_data & st_seen_q)
                tc_q <= 1'b0;
        end
    end

    // Pin drive and interrupt, all from flops
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_data_pin <= 1'b1;
            tx_data_oe  <= 1'b0;
            irq         <= 1'b0;
            irq_level   <= 1'b0;
        end else begin
            // Pin comes from a flop so decode glitches never reach the line
            // R05 released when both directions off
            tx_data_oe <= te | ctrl2_q[`AST_C2_RE];
            case (state_q)
                // R04 start low unless idle frame
                ST_START: tx_data_pin <= idle_frm_q;
                ST_DATA:  tx_data_pin <= shift_q[0];
                // R06 idle is all ones; R04 stop high except break
                ST_STOP:  tx_data_pin <= ~brk_frm_q;
                // R18 line stays low between repeated break frames
                ST_IDLE:  tx_data_pin <= ~(brk_dly_q & send_break_bit);
                default:  tx_data_pin <= 1'b1;
            endcase
            // R13 empty and complete interrupts gated by cpu mask on irq; irq_level is gated by imask_q only
            irq <= ~cpu_int_mask & (empty_req | done_req);
            irq_level <= (tde_q & imask_q[1]) | (tc_q & imask_q[0]);
        end
    end
endmodule // ast_uart_tx
`default_nettype wire

//--- core/ast_regs.vh
// Register map, field positions, reset values and timing counts of the serial transmitter.
// Assumes a classic Wishbone slave with 32-bit data; each register takes one aligned word.
// Overview of operation
// R01 - Start, 8/9 data bits LSB first, stop
// R02 - Word length select chooses 8 or 9
// R03 - Ninth data bit comes from ninth_tx_bit
// R04 - Start bit low, stop bit high
// R05 - Pin released when both directions disabled
// R06 - Idle character is a full frame of ones
// R07 - Break frames zero, then one extra high
// R08 - Separate programmable transmit and receive baud generators
// R09 - Receive input oversampled against noise
// R10 - Transmitter enable sends idle frame first
// R11 - Empty flag cleared by status access, data write
// R12 - Empty flag set when buffer transfers out
// R13 - Empty interrupt when flag and enable set
// R14 - Write during frame goes to holding buffer
// R15 - Write while idle loads shifter, starts frame
// R16 - Complete flag set at frame end, interrupts
// R17 - Complete flag cleared by same sequence
// R18 - Break frames repeat while send break set
// R19 - 8-bit mode ignores ninth bit
`ifndef AST_REGS_VH
`define AST_REGS_VH
// Byte addresses
`define AST_ADDR_STATUS   8'h00
`define AST_ADDR_DATA     8'h04
`define AST_ADDR_CTRL1    8'h08
`define AST_ADDR_CTRL2    8'h0C
`define AST_ADDR_TXBAUD   8'h10
`define AST_ADDR_RXBAUD   8'h14
`define AST_ADDR_IMASK    8'h18
// serial_status_reg fields
`define AST_ST_TDE        7
`define AST_ST_TC         6
// serial_control_reg_one fields
`define AST_C1_T8         6
`define AST_C1_M          4
// Second control register fields
`define AST_C2_TIE        7
`define AST_C2_TX_COMPLETE_INT_ENABLE       6
`define AST_C2_TE         3
`define AST_C2_RE         2
`define AST_C2_SBK        0
// Reset values
`define AST_RST_CTRL      8'h00
`define AST_RST_BAUD      16'h0001
`define AST_RST_STATUS    2'h3
// Baud tick is 16 oversample ticks; divider counts core cycles per oversample tick
`define AST_OVS           4'hF
`define AST_CLK_HZ        100000000
`define AST_MAX_BAUD      500000
`endif

//--- verification/ast_uart_tx_checker.sv
// Concurrent checks on the serial transmitter ports: bus handshake, line timing, interrupt gating.
// Assumes the tx baud divisor stays at 1 (16 core cycles a bit) and one core clock.
`timescale 1ns/1ps
`default_nettype none
module ast_uart_tx_checker (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Bus handshake
    input  wire logic wb_cyc_i,
    input  wire logic wb_stb_i,
    input  wire logic wb_ack_o,
    // Serial pin and interrupt
    input  wire logic tx_data_pin,
    input  wire logic tx_data_oe,
    input  wire logic cpu_int_mask,
    input  wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Acknowledge is a single-cycle pulse
    chk_ack_pulse_only: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack while bus idle");
    // Short glitches on the line would break framing; every low level, and every high level while oe is set, lasts at least half a bit
    chk_low_bit_hold: assert property ($fell(tx_data_pin) |-> !tx_data_pin [*8])
        else $error("low level shorter than half a bit");
    chk_high_bit_hold: assert property ($rose(tx_data_pin) && tx_data_oe |-> tx_data_pin [*8])
        else $error("high level shorter than half a bit");
    chk_enable_idle_first: assert property ($rose(tx_data_oe) |-> tx_data_pin [*8])
        else $error("pin not high after enable");
    chk_irq_cpu_masked: assert property ($past(cpu_int_mask) |-> !irq)
        else $error("irq raised while cpu mask set");
endmodule // ast_uart_tx_checker
`default_nettype wire

//--- verification/ast_rx_model.sv
// Behavioural receiver on the transmit pin, sampling each data and stop bit in its middle.
// Assumes a fixed bit time in core cycles and a line that idles high.
`timescale 1ns/1ps
`default_nettype none
module ast_rx_model #(
    parameter int BIT = 16
) (
    // Clock and serial line
    input  wire logic       core_clk,
    input  wire logic       line,
    input  wire logic       nine,
    // Last frame seen
    output var  logic [8:0] word,
    output var  logic       stop_bit,
    output var  int         frames
);
    logic [8:0] w;
    initial begin
        frames = 0;
        word = 9'h000;
        stop_bit = 1'b0;
        forever begin
            @(posedge core_clk);
            if (line === 1'b0) begin
                w = 9'h000;
                repeat (BIT / 2) @(posedge core_clk);
                for (int i = 0; i < (nine ? 9 : 8); i++) begin
                    repeat (BIT) @(posedge core_clk);
                    w[i] = line;
                end
                repeat (BIT) @(posedge core_clk);
                word = w;
                stop_bit = line;
                frames++;
                // Break keeps the line low, so wait for release before hunting again
                while (line !== 1'b1) @(posedge core_clk);
            end
        end
    end
endmodule // ast_rx_model
`default_nettype wire

//--- verification/ast_uart_tx_test.sv
// Self-checking bench for the serial transmitter: Wishbone tasks plus frame checks.
// Assumes tx divisor 1 (16 core cycles a bit) and the receiver model on the pin.
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.vh"
module ast_uart_tx_test;
    localparam int BIT = 16;
    logic        core_clk, rst, cyc, stb, we, mask_cpu, nine;
    logic [7:0]  adr;
    logic [31:0] dat, rd;
    wire  [31:0] dat_o;
    wire         ack, pin, oe, irq, irq_lvl, stop_bit;
    wire  [8:0]  word;
    int          frames, err_total, checks_done, n, f;

    ast_uart_tx DUT (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .tx_data_pin(pin), .tx_data_oe(oe), .rx_data_pin(1'b1), .cpu_int_mask(mask_cpu),
        .irq(irq), .irq_level(irq_lvl));
    ast_rx_model #(.BIT(BIT)) u_rx (.core_clk(core_clk), .line(pin), .nine(nine),
        .word(word), .stop_bit(stop_bit), .frames(frames));

    // Classic single cycle; release only at the edge that sees ack
    task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        @(posedge core_clk);
        while (ack !== 1'b1 && t < 50) begin
            @(posedge core_clk);
            t++;
        end
        if (t == 50) err_total++;
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_frame(input int k);
        int t;
        t = 0;
        while (frames < k && t < 4000) begin
            @(posedge core_clk);
            t++;
        end
        chk("frame arrived", 1, frames >= k);
    endtask
    // Cycles until the pin reaches a level, capped so a stuck line cannot hang
    task automatic run_until(input logic lvl);
        n = 0;
        while (pin !== lvl && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        if (pin !== lvl) err_total++;
    endtask
    task automatic give_verdict;
        if (err_total == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Clock, reset and time-zero inputs
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rst, cyc, stb, we, mask_cpu, nine, adr, dat} = {1'b1, 5'h00, 8'h00, 32'h0};
        err_total = 0;
        checks_done = 0;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        chk("status reset", 32'hC0, rd);
        wb_xfer(0, `AST_ADDR_TXBAUD, 0);
        chk("tx divisor reset", 32'h1, rd);
        wb_xfer(1, 8'h40, 32'hFF);
        wb_xfer(0, 8'h40, 0);
        chk("unmapped read", 32'h0, rd);
        wb_xfer(1, `AST_ADDR_CTRL1, 32'h00);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h08);
        @(posedge core_clk);
        chk("oe after enable", 1, oe);
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        wb_xfer(1, `AST_ADDR_DATA, 32'hA5);
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        chk("flags cleared", 32'h00, rd & 32'hC0);
        run_until(0);
        chk("idle frame first", 1, n >= 10 * BIT - 12);
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        chk("empty on transfer", 32'hC0, rd & 32'hC0);
        wb_xfer(1, `AST_ADDR_DATA, 32'h5A);
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        chk("holding loaded", 32'h00, rd & 32'hC0);
        wait_frame(1);
        chk("first byte", 32'h0A5, word);
        chk("first stop", 1, stop_bit);
        wait_frame(2);
        chk("queued byte", 32'h05A, word);
        repeat (2 * BIT) @(posedge core_clk);
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        chk("complete set", 32'hC0, rd & 32'hC0);
        wb_xfer(1, `AST_ADDR_IMASK, 32'hC0);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h88);
        repeat (2) @(posedge core_clk);
        chk("empty irq", 1, irq);
        chk("irq level", 1, irq_lvl);
        mask_cpu <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("cpu masked", 0, irq);
        mask_cpu <= 1'b0;
        wb_xfer(1, `AST_ADDR_IMASK, 32'h00);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h48);
        repeat (2) @(posedge core_clk);
        chk("complete irq", 1, irq);
        chk("level masked", 0, irq_lvl);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h08);
        for (f = 0; f < 2; f++) begin
            nine <= 1'b1;
            wb_xfer(1, `AST_ADDR_CTRL1, f ? 32'h50 : 32'h10);
            wb_xfer(0, `AST_ADDR_STATUS, 0);
            wb_xfer(1, `AST_ADDR_DATA, 32'h0F);
            wait_frame(3 + f);
            chk("nine bit word", {23'h0, f[0], 8'h0F}, word);
            chk("nine bit stop", 1, stop_bit);
            repeat (2 * BIT) @(posedge core_clk);
        end
        nine <= 1'b0;
        wb_xfer(1, `AST_ADDR_CTRL1, 32'h00);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h09);
        wait_frame(5);
        chk("break word", 32'h0, {stop_bit, word});
        repeat (30 * BIT) @(posedge core_clk);
        chk("break repeats", 0, pin);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h08);
        run_until(1);
        wb_xfer(0, `AST_ADDR_STATUS, 0);
        wb_xfer(1, `AST_ADDR_DATA, 32'h3C);
        run_until(0);
        chk("high after break", 1, n >= BIT / 2);
        wait_frame(6);
        chk("byte after break", 32'h03C, word);
        chk("stop after break", 1, stop_bit);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h04);
        repeat (2) @(posedge core_clk);
        chk("receiver only oe", 1, oe);
        chk("idle pin high", 1, pin);
        wb_xfer(1, `AST_ADDR_CTRL2, 32'h00);
        repeat (2) @(posedge core_clk);
        chk("pin released", 0, oe);
        give_verdict;
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        repeat (50000) @(posedge core_clk);
        err_total++;
        give_verdict;
    end
endmodule // ast_uart_tx_test
bind ast_uart_tx ast_uart_tx_checker u_chk (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_data_pin(tx_data_pin), .tx_data_oe(tx_data_oe),
    .cpu_int_mask(cpu_int_mask), .irq(irq));
`default_nettype wire
